// File: alarm_trim_pkg.sv
/*
  shared constants and types for the alarm mask and sample timing register group.
  assumes one clock domain and a plain register port with 10-bit byte addresses.
*/
package alarm_trim_pkg;

    // ==========================================================
    // address map
    localparam logic [9:0] SUMMARY_OFFSET   = 10'h2C0;
    localparam logic [9:0] STATUS_OFFSET    = 10'h2C1;
    localparam logic [9:0] MASK_OFFSET      = 10'h2C2;
    localparam logic [9:0] LANE_OFFSET      = 10'h2C4;
    localparam logic [9:0] TRIM_A_DUAL_OFS  = 10'h310;
    localparam logic [9:0] TRIM_B_DUAL_OFS  = 10'h313;
    localparam logic [9:0] TRIM_A_SINA_OFS  = 10'h314;
    localparam logic [9:0] TRIM_B_SINA_OFS  = 10'h315;
    localparam logic [9:0] IRQ_ENABLE_OFS   = 10'h3E0;
    localparam logic [9:0] IRQ_STATUS_OFS   = 10'h3E1;
    localparam logic [9:0] IRQ_CLEAR_OFS    = 10'h3E2;

    // ==========================================================
    // fields and reset values
    localparam int          NUM_ALARMS      = 6;
    localparam int          FIFO_BIT        = 5;
    localparam logic [5:0]  MASK_RESET      = 6'h3F;
    localparam logic [5:0]  STATUS_RESET    = 6'h3F;
    localparam logic [15:0] LANE_RESET      = 16'hFFFF;
    localparam logic [1:0]  IRQ_EN_RESET    = 2'h0;
    localparam int          IRQ_SUMMARY_BIT = 0;
    localparam int          IRQ_LANE_BIT    = 1;

    // ==========================================================
    // types
    typedef struct packed {
        logic       lane_fifo_fault;
        logic       lock_loss_fault;
        logic       serial_link_fault;
        logic       clock_realign_event;
        logic       oscillator_phase_fault;
        logic       divider_mismatch_fault;
    } alarm_src_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] coreADual;
        logic [7:0] coreBDual;
        logic [7:0] coreASingleIna;
        logic [7:0] coreBSingleIna;
    } trim_set_t;

endpackage

// File: alarm_trim_regs.sv
/*
  alarm status, mask, lane FIFO alarm vector, sampling trim registers and interrupt.
  assumes alarm sources and lane faults are level inputs already on clk_sys.
*/
module alarm_trim_regs
#(
    parameter int         NUM_LANES = 16,
    parameter logic [7:0] TRIM_A_DUAL_FUSE = 8'h00,
    parameter logic [7:0] TRIM_B_DUAL_FUSE = 8'h00,
    parameter logic [7:0] TRIM_A_SINA_FUSE = 8'h00,
    parameter logic [7:0] TRIM_B_SINA_FUSE = 8'h00
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire alarm_trim_pkg::reg_req_t  regReq,
    output logic [15:0]                    rdData,
    input  wire alarm_trim_pkg::alarm_src_t alarmSrc,
    input  wire logic [NUM_LANES-1:0]      laneFault,
    output alarm_trim_pkg::trim_set_t      trimSet,
    output logic                           statusOutputPin,
    output logic                           irq
);
    import alarm_trim_pkg::*;

    // ==========================================================
    // write decode
    logic       wrMask;
    logic       wrStatus;
    logic       wrLane;
    logic       wrIrqEn;
    logic       wrIrqClr;
    logic       wrTrimAD;
    logic       wrTrimBD;
    logic       wrTrimAS;
    logic       wrTrimBS;

    assign wrMask   = regReq.wr && regReq.addr == MASK_OFFSET;
    assign wrStatus = regReq.wr && regReq.addr == STATUS_OFFSET;
    assign wrLane   = regReq.wr && regReq.addr == LANE_OFFSET;
    assign wrIrqEn  = regReq.wr && regReq.addr == IRQ_ENABLE_OFS;
    assign wrIrqClr = regReq.wr && regReq.addr == IRQ_CLEAR_OFS;
    assign wrTrimAD = regReq.wr && regReq.addr == TRIM_A_DUAL_OFS;
    assign wrTrimBD = regReq.wr && regReq.addr == TRIM_B_DUAL_OFS;
    assign wrTrimAS = regReq.wr && regReq.addr == TRIM_A_SINA_OFS;
    assign wrTrimBS = regReq.wr && regReq.addr == TRIM_B_SINA_OFS;

    // ==========================================================
    // alarm mask
    logic [5:0] mask_reg;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mask_reg <= MASK_RESET;
        else if (wrMask)
            mask_reg <= regReq.wdata[5:0];
    end

    // ==========================================================
    // lane alarm vector
    logic [NUM_LANES-1:0] lane_reg;
    logic [NUM_LANES-1:0] lane_next;
    logic [NUM_LANES-1:0] laneClr;

    always_comb
    begin
        laneClr = '0;
        if (wrLane)
            laneClr = regReq.wdata[NUM_LANES-1:0];
        if (wrStatus && regReq.wdata[FIFO_BIT])
            laneClr = '1;
        lane_next = (lane_reg & ~laneClr) | laneFault;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            lane_reg <= NUM_LANES'(LANE_RESET);
        else
            lane_reg <= lane_next;
    end

    // ==========================================================
    // alarm status flags
    logic [5:0] status_reg;
    logic [5:0] statusSet;
    logic [5:0] statusClr;

    assign statusSet = {|laneFault, alarmSrc[4:0]};
    assign statusClr = wrStatus ? regReq.wdata[5:0] : 6'h00;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            status_reg <= STATUS_RESET;
        else
            status_reg <= (status_reg & ~statusClr) | statusSet;
    end

    logic summary;
    assign summary = |(status_reg & ~mask_reg);

    // ==========================================================
    // interrupts: summary rising edge and new lane fault edge
    logic [1:0] irqEn_reg;
    logic [1:0] irqSt_reg;
    logic [1:0] irqEvt;
    logic [1:0] irqClr;
    logic       summary_reg;

    assign irqEvt = {|(lane_next & ~lane_reg), summary & ~summary_reg};
    assign irqClr = wrIrqClr ? regReq.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            summary_reg <= 1'b0;
        else
            summary_reg <= summary;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            irqEn_reg <= IRQ_EN_RESET;
        else if (wrIrqEn)
            irqEn_reg <= regReq.wdata[1:0];
    end

    // set wins over clear so no event is lost
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            irqSt_reg <= 2'h0;
        else
            irqSt_reg <= (irqSt_reg & ~irqClr) | irqEvt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            irq             <= 1'b0;
            statusOutputPin <= 1'b0;
        end
        else
        begin
            irq             <= |(((irqSt_reg & ~irqClr) | irqEvt) & irqEn_reg);
            statusOutputPin <= summary;
        end
    end

    // ==========================================================
    // sampling trim registers, each on its own strobe
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            trimSet.coreADual      <= TRIM_A_DUAL_FUSE;
            trimSet.coreBDual      <= TRIM_B_DUAL_FUSE;
            trimSet.coreASingleIna <= TRIM_A_SINA_FUSE;
            trimSet.coreBSingleIna <= TRIM_B_SINA_FUSE;
        end
        else
        begin
            if (wrTrimAD)
                trimSet.coreADual <= regReq.wdata[7:0];
            if (wrTrimBD)
                trimSet.coreBDual <= regReq.wdata[7:0];
            if (wrTrimAS)
                trimSet.coreASingleIna <= regReq.wdata[7:0];
            if (wrTrimBS)
                trimSet.coreBSingleIna <= regReq.wdata[7:0];
        end
    end

    // ==========================================================
    // read port, data in the following cycle; unmapped reads zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdData <= 16'h0000;
        else if (!regReq.rd)
            rdData <= 16'h0000;
        else if (regReq.addr == SUMMARY_OFFSET)
            rdData <= {15'h0000, summary};
        else if (regReq.addr == STATUS_OFFSET)
            rdData <= {10'h000, status_reg};
        else if (regReq.addr == MASK_OFFSET)
            rdData <= {10'h000, mask_reg};
        else if (regReq.addr == LANE_OFFSET)
            rdData <= 16'(lane_reg);
        else if (regReq.addr == TRIM_A_DUAL_OFS)
            rdData <= {8'h00, trimSet.coreADual};
        else if (regReq.addr == TRIM_B_DUAL_OFS)
            rdData <= {8'h00, trimSet.coreBDual};
        else if (regReq.addr == TRIM_A_SINA_OFS)
            rdData <= {8'h00, trimSet.coreASingleIna};
        else if (regReq.addr == TRIM_B_SINA_OFS)
            rdData <= {8'h00, trimSet.coreBSingleIna};
        else if (regReq.addr == IRQ_ENABLE_OFS)
            rdData <= {14'h0000, irqEn_reg};
        else if (regReq.addr == IRQ_STATUS_OFS)
            rdData <= {14'h0000, irqSt_reg};
        else
            rdData <= 16'h0000;
    end

endmodule

// File: alarm_trim_regs_properties.sv
/* port assertions for the alarm and trim register group.
   assumes the bind at the foot and one clock domain. */
module alarm_trim_regs_properties
#(
    parameter int NUM_LANES = 16
)
(
    input wire logic                      clk_sys,
    input wire logic                      reset,
    input wire alarm_trim_pkg::reg_req_t  regReq,
    input wire logic [15:0]               rdData,
    input wire logic [NUM_LANES-1:0]      laneFault,
    input wire alarm_trim_pkg::trim_set_t trimSet,
    input wire logic                      statusOutputPin
);
    import alarm_trim_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ========
    // lane write, idle gap, lane read
    sequence s_wgr;
        regReq.wr && regReq.addr == LANE_OFFSET ##1 !regReq.wr
        ##1 regReq.rd && regReq.addr == LANE_OFFSET;
    endsequence
    // faults in the gap may set bits again, so they are excluded
    property p_clr;
        s_wgr |=> (rdData & $past(regReq.wdata, 3) & ~16'($past(laneFault, 3))
            & ~16'($past(laneFault, 2))) == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("lane flag not cleared");
    property p_keep;
        s_wgr |=> (rdData & 16'($past(laneFault, 3))) == 16'($past(laneFault, 3));
    endproperty
    a_keep: assert property (p_keep) else $error("lane clear beat fault");
    property p_pin;
        regReq.rd && regReq.addr == SUMMARY_OFFSET |=> rdData[0] == statusOutputPin;
    endproperty
    a_pin: assert property (p_pin) else $error("pin differs from summary");
    // ========
    // trims
    property p_ta;
        regReq.wr && regReq.addr == TRIM_A_DUAL_OFS |=>
            trimSet.coreADual == $past(regReq.wdata[7:0]);
    endproperty
    a_ta: assert property (p_ta) else $error("core a dual trim");
    property p_tb;
        regReq.wr && regReq.addr == TRIM_B_DUAL_OFS |=>
            trimSet.coreBDual == $past(regReq.wdata[7:0]);
    endproperty
    a_tb: assert property (p_tb) else $error("core b dual trim");
    property p_tas;
        regReq.wr && regReq.addr == TRIM_A_SINA_OFS |=>
            trimSet.coreASingleIna == $past(regReq.wdata[7:0]);
    endproperty
    a_tas: assert property (p_tas) else $error("core a single trim");
    property p_tbs;
        regReq.wr && regReq.addr == TRIM_B_SINA_OFS |=>
            trimSet.coreBSingleIna == $past(regReq.wdata[7:0]);
    endproperty
    a_tbs: assert property (p_tbs) else $error("core b single trim");
    property p_hold;
        !(regReq.wr && regReq.addr == TRIM_A_DUAL_OFS) |=> $stable(trimSet.coreADual);
    endproperty
    a_hold: assert property (p_hold) else $error("trim disturbed");
endmodule

bind alarm_trim_regs alarm_trim_regs_properties #(.NUM_LANES(NUM_LANES)) props (
    .clk_sys(clk_sys), .reset(reset), .regReq(regReq), .rdData(rdData),
    .laneFault(laneFault), .trimSet(trimSet), .statusOutputPin(statusOutputPin));

// File: alarm_trim_regs_test.sv
/* self-checking bench for the alarm and trim register group.
   assumes design and checker are compiled first. */
module alarm_trim_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import alarm_trim_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    reg_req_t    regReq = '0;
    alarm_src_t  alarmSrc = '0;
    logic [15:0] laneFault = '0;
    logic [15:0] rdData;
    trim_set_t   trimSet;
    logic        statusOutputPin;
    logic        irq;
    int          fail_count = 0;
    int          n_checks = 0;
    integer      seed = 32'hC98B;
    logic [15:0] d;
    logic [15:0] v;
    logic [7:0]  t [4] = '{default: 8'h00};
    logic [9:0]  ofs [4] = '{TRIM_A_DUAL_OFS, TRIM_B_DUAL_OFS, TRIM_A_SINA_OFS, TRIM_B_SINA_OFS};
    int          k;
    always #5 clk_sys = ~clk_sys;
    alarm_trim_regs dut (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .rdData(rdData),
        .alarmSrc(alarmSrc), .laneFault(laneFault), .trimSet(trimSet),
        .statusOutputPin(statusOutputPin), .irq(irq));
    // ========
    // tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        regReq <= '{a, w, 1'b1, 1'b0};
        @(posedge clk_sys);
        regReq.wr <= 1'b0;
    endtask
    // data stand one cycle only, so sample just after the answer edge
    task automatic rd(input logic [9:0] a);
        @(posedge clk_sys);
        regReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        regReq.rd <= 1'b0;
        #1 d = rdData;
    endtask
    function automatic logic summ(input logic [5:0] s, input logic [5:0] m);
        return |(s & ~m);
    endfunction
    // ========
    // scenarios
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rd(MASK_OFFSET);
        chk("mask", 32'h003F, d);
        rd(LANE_OFFSET);
        chk("lane", 32'hFFFF, d);
        rd(STATUS_OFFSET);
        chk("status", 32'h003F, d);
        rd(SUMMARY_OFFSET);
        chk("summary", summ(STATUS_RESET, MASK_RESET), d);
        chk("trims", 32'h0, trimSet);
        for (k = 0; k < 8; k++)
        begin
            d = $random(seed);
            t[k % 4] = d[7:0];
            wr(ofs[k % 4], d);
            rd(ofs[k % 4]);
            chk("trim", t[k % 4], d);
            chk("trimSet", {t[0], t[1], t[2], t[3]}, trimSet);
        end
        wr(STATUS_OFFSET, 16'h003F);
        wr(LANE_OFFSET, 16'hFFFF);
        rd(LANE_OFFSET);
        chk("lane", 32'h0, d);
        v = $random(seed) | 1;
        @(posedge clk_sys);
        laneFault <= v;
        wr(LANE_OFFSET, 16'hFFFF);
        laneFault <= '0;
        rd(LANE_OFFSET);
        chk("lane", v, d);
        rd(STATUS_OFFSET);
        chk("status", 32'h0020, d);
        wr(LANE_OFFSET, 16'h0000);
        rd(LANE_OFFSET);
        chk("lane", v, d);
        rd(IRQ_STATUS_OFS);
        chk("irq status", 32'h2, d);
        chk("irq", 1'b0, irq);
        wr(STATUS_OFFSET, 16'h0020);
        rd(LANE_OFFSET);
        chk("lane", 32'h0, d);
        k = $unsigned($random(seed)) % 5;
        wr(MASK_OFFSET, 16'h00C0);
        rd(MASK_OFFSET);
        chk("mask", 32'h0, d);
        wr(IRQ_CLEAR_OFS, 16'h0003);
        wr(IRQ_ENABLE_OFS, 16'h0001);
        @(posedge clk_sys);
        alarmSrc <= alarm_src_t'(6'h01 << k);
        @(posedge clk_sys);
        alarmSrc <= '0;
        rd(SUMMARY_OFFSET);
        chk("summary", summ(6'h01 << k, 6'h00), d);
        chk("pin", 1'b1, statusOutputPin);
        wr(MASK_OFFSET, 16'h0001 << k);
        chk("irq", 1'b1, irq);
        rd(SUMMARY_OFFSET);
        chk("summary", summ(6'h01 << k, 6'h01 << k), d);
        wr(IRQ_CLEAR_OFS, 16'h0003);
        rd(IRQ_STATUS_OFS);
        chk("irq status", 32'h0, d);
        chk("irq", 1'b0, irq);
        rd(10'h100);
        chk("unmapped", 32'h0, d);
        tally_and_finish();
    end
    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
endmodule
